// >>> hdl/drs_top.v
// Device reset supervisor: reset sources, supply monitors, watchdog, status
`timescale 1ns/1ps
`include "drs_consts.vh"

module drs_top #(
   parameter WDT_TICK = `DRS_WDT_TICK_CYC,
   parameter BUZZ_ON = `DRS_BUZZ_ON_CYC
) (
   input wire clk, // System clock, 125 MHz
   input wire rst_n, // Initial power monitor output, low while supplies low
   input wire external_reset_n, // External reset pin, active low
   input wire precise_low_voltage_reset_trip, // Precise monitor comparator, high on fault
   input wire analog_low_voltage_irq_cmp, // Analog low-voltage comparator, high below level
   input wire digital_low_voltage_irq_cmp, // Digital low-voltage comparator, high below level
   input wire analog_high_voltage_irq_cmp, // Analog high-voltage comparator, high above level
   input wire sleep_mode, // Power manager: sleep
   input wire hibernate_mode, // Power manager: hibernate
   input wire [`DRS_ADDR_W-1:0] address, // Avalon byte address
   input wire read, // Avalon read
   input wire write, // Avalon write
   input wire [31:0] writedata, // Avalon write data
   output reg [31:0] readdata, // Avalon read data
   output wire waitrequest, // Avalon wait request
   output reg device_reset_n, // Device-wide reset, active low
   output reg initial_power_monitor_mon_en, // Initial power monitor enable
   output reg precise_low_voltage_reset_dig_en, // Digital precise monitor enable
   output reg precise_low_voltage_reset_ana_en, // Analog precise monitor enable
   output reg analog_reg_en, // Analog regulator enable
   output reg analog_low_voltage_irq_mon_en, // Analog low-voltage monitor enable
   output reg digital_low_voltage_irq_mon_en, // Digital low-voltage monitor enable
   output reg analog_high_voltage_irq_mon_en, // Analog high-voltage monitor enable
   output reg [3:0] analog_low_voltage_irq_trip_level, // Analog trip level code
   output reg [3:0] digital_low_voltage_irq_trip_level, // Digital trip level code
   output reg monitor_irq, // Monitor interrupt to processor
   output reg wake_req // Wake request to power manager
);

   localparam STRETCH = (`DRS_INITIAL_POWER_MONITOR_MIN_NS * 1000 + `DRS_CLK_PS - 1) / `DRS_CLK_PS;
   localparam [7:0] STRETCH_CNT = STRETCH[7:0];
   localparam [15:0] BUZZ_ON_CNT = BUZZ_ON[15:0];
   localparam [15:0] WDT_TICK_CNT = WDT_TICK[15:0];

   // async assert
   // Any raw source reloads the stretch counter with STRETCH_CNT at once; release waits for clk
   wire raw_rst_n = rst_n & external_reset_n & ~(precise_low_voltage_reset_trip & precise_low_voltage_reset_dig_en);

   reg [7:0] stretch_q;
   reg sync_req;
   always @(posedge clk or negedge raw_rst_n) begin
      if (!raw_rst_n) begin
         stretch_q <= STRETCH_CNT;
         device_reset_n <= 1'b0;
      end else begin
         if (sync_req) begin
            stretch_q <= STRETCH_CNT;
            device_reset_n <= 1'b0;
         end else if (stretch_q != 8'h00) begin
            stretch_q <= stretch_q - 8'h01;
            device_reset_n <= 1'b0;
         end else begin
            device_reset_n <= 1'b1;
         end
      end
   end

   // Pin inputs: three stages, change accepted once stages two and three agree
   reg [2:0] xr_s, pr_s, al_s, dl_s, ah_s;
   reg xr_f, pr_f, al_f, dl_f, ah_f;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         xr_s <= 3'h7;
         pr_s <= 3'h0;
         al_s <= 3'h0;
         dl_s <= 3'h0;
         ah_s <= 3'h0;
         xr_f <= 1'b1;
         pr_f <= 1'b0;
         al_f <= 1'b0;
         dl_f <= 1'b0;
         ah_f <= 1'b0;
      end else begin
         xr_s <= {xr_s[1:0], external_reset_n};
         pr_s <= {pr_s[1:0], precise_low_voltage_reset_trip};
         al_s <= {al_s[1:0], analog_low_voltage_irq_cmp};
         dl_s <= {dl_s[1:0], digital_low_voltage_irq_cmp};
         ah_s <= {ah_s[1:0], analog_high_voltage_irq_cmp};
         if (xr_s[1] == xr_s[2])
            xr_f <= xr_s[2];
         if (pr_s[1] == pr_s[2])
            pr_f <= pr_s[2];
         if (al_s[1] == al_s[2])
            al_f <= al_s[2];
         if (dl_s[1] == dl_s[2])
            dl_f <= dl_s[2];
         if (ah_s[1] == ah_s[2])
            ah_f <= ah_s[2];
      end
   end

   // Power-on domain: survives all but the initial power monitor
   reg por_done_q;
   reg wdt_en_q;
   reg [7:0] status_q;
   reg [7:0] status_set;
   wire acc_ok;
   wire wr_ctrl = write & acc_ok & (address == `DRS_OFS_CTRL);
   wire wr_wdt = write & acc_ok & (address == `DRS_OFS_WDT_CTRL);
   wire wr_stat = write & acc_ok & (address == `DRS_OFS_STATUS);

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         por_done_q <= 1'b0;
         wdt_en_q <= 1'b0;
         status_q <= 8'h00;
      end else begin
         if (device_reset_n)
            por_done_q <= 1'b1;
         if (wr_wdt & writedata[`DRS_WDT_EN_BIT])
            wdt_en_q <= 1'b1;
         status_q <= (status_q & ~(wr_stat ? (writedata[7:0] & `DRS_ST_IRQ_MASK) : 8'h00))
                     | status_set;
      end
   end

   // Device domain: control registers, watchdog, buzz
   reg [7:0] ctrl_q;
   reg [7:0] level_q;
   reg [15:0] wdt_timeout_q;
   reg [15:0] buzz_period_q;
   reg [15:0] wdt_tick_q;
   reg [15:0] wdt_cnt_q;
   reg [15:0] buzz_cnt_q;
   reg buzz_q;
   reg ack_q;
   reg [2:0] irq_pend_q;

   wire sw_req = wr_ctrl & writedata[`DRS_CTRL_SW_RESET] & ~ctrl_q[`DRS_CTRL_SW_BLOCK];
   wire wdt_req = wdt_en_q & (wdt_cnt_q >= wdt_timeout_q) & (wdt_tick_q == 16'h0000);
   wire analog_low_voltage_irq_ev = al_f & analog_low_voltage_irq_mon_en;
   wire digital_low_voltage_irq_ev = dl_f & digital_low_voltage_irq_mon_en;
   wire analog_high_voltage_irq_ev = ah_f & analog_high_voltage_irq_mon_en;
   wire lvi_req = (analog_low_voltage_irq_ev & ctrl_q[`DRS_CTRL_ANALOG_LOW_VOLTAGE_IRQ_RST]) | (digital_low_voltage_irq_ev & ctrl_q[`DRS_CTRL_DIGITAL_LOW_VOLTAGE_IRQ_RST]);
   wire in_sleep = sleep_mode | hibernate_mode;

   always @* begin
      sync_req = sw_req | wdt_req | lvi_req;
      status_set = 8'h00;
      status_set[`DRS_ST_EXTERNAL_RESET_N] = ~xr_f;
      status_set[`DRS_ST_PRECISE_LOW_VOLTAGE_RESET] = pr_f & precise_low_voltage_reset_dig_en;
      status_set[`DRS_ST_SOFTWARE_RESET] = sw_req;
      status_set[`DRS_ST_WATCHDOG_RESET] = wdt_req;
      status_set[`DRS_ST_LVI_RST] = lvi_req;
      status_set[`DRS_ST_ANALOG_LOW_VOLTAGE_IRQ] = analog_low_voltage_irq_ev & ~ctrl_q[`DRS_CTRL_ANALOG_LOW_VOLTAGE_IRQ_RST];
      status_set[`DRS_ST_DIGITAL_LOW_VOLTAGE_IRQ] = digital_low_voltage_irq_ev & ~ctrl_q[`DRS_CTRL_DIGITAL_LOW_VOLTAGE_IRQ_RST];
      status_set[`DRS_ST_ANALOG_HIGH_VOLTAGE_IRQ] = analog_high_voltage_irq_ev;
   end

   // Avalon: one wait cycle, write lands on the cycle waitrequest drops
   assign waitrequest = (read | write) & ~ack_q;
   assign acc_ok = ack_q;

   // all control state except wdt_en_q follows device reset
   always @(posedge clk or negedge device_reset_n) begin
      if (!device_reset_n) begin
         ctrl_q <= `DRS_CTRL_RESET;
         level_q <= `DRS_LEVEL_RESET;
         wdt_timeout_q <= `DRS_WDT_TIMEOUT_RESET;
         buzz_period_q <= `DRS_BUZZ_PERIOD_RESET;
         wdt_tick_q <= WDT_TICK_CNT;
         wdt_cnt_q <= 16'h0000;
         buzz_cnt_q <= 16'h0000;
         buzz_q <= 1'b0;
         ack_q <= 1'b0;
         readdata <= 32'h00000000;
         irq_pend_q <= 3'h0;
      end else begin
         ack_q <= (read | write) & ~ack_q;
         if (read & ~ack_q) begin
            case (address)
               `DRS_OFS_CTRL: readdata <= {24'h000000, ctrl_q};
               `DRS_OFS_LEVEL: readdata <= {24'h000000, level_q};
               `DRS_OFS_WDT_CTRL: readdata <= {31'h00000000, wdt_en_q};
               `DRS_OFS_WDT_TIMEOUT: readdata <= {16'h0000, wdt_timeout_q};
               `DRS_OFS_BUZZ_PERIOD: readdata <= {16'h0000, buzz_period_q};
               `DRS_OFS_STATUS: readdata <= {24'h000000, status_q};
               `DRS_OFS_MON_STATE: readdata <= {22'h000000, buzz_q, por_done_q,
                  xr_f, pr_f, al_f, dl_f, ah_f, monitor_irq, wake_req, ~device_reset_n};
               default: readdata <= 32'h00000000;
            endcase
         end
         if (wr_ctrl)
            ctrl_q <= {writedata[7:1], 1'b0};
         if (write & acc_ok & (address == `DRS_OFS_LEVEL))
            level_q <= writedata[7:0];
         if (write & acc_ok & (address == `DRS_OFS_WDT_TIMEOUT))
            wdt_timeout_q <= writedata[15:0];
         if (write & acc_ok & (address == `DRS_OFS_BUZZ_PERIOD))
            buzz_period_q <= writedata[15:0];
         if (~wdt_en_q | (wr_wdt & writedata[`DRS_WDT_KICK_BIT])) begin
            wdt_cnt_q <= 16'h0000;
            wdt_tick_q <= WDT_TICK_CNT;
         end else if (wdt_tick_q == 16'h0000) begin
            wdt_tick_q <= WDT_TICK_CNT;
            if (wdt_cnt_q != 16'hffff)
               wdt_cnt_q <= wdt_cnt_q + 16'h0001;
         end else begin
            wdt_tick_q <= wdt_tick_q - 16'h0001;
         end
         if (sleep_mode & ~hibernate_mode) begin
            if (buzz_cnt_q >= buzz_period_q) begin
               buzz_cnt_q <= 16'h0000;
               buzz_q <= 1'b1;
            end else begin
               buzz_cnt_q <= buzz_cnt_q + 16'h0001;
               if (buzz_cnt_q >= BUZZ_ON_CNT)
                  buzz_q <= 1'b0;
            end
         end else begin
            buzz_cnt_q <= 16'h0000;
            buzz_q <= 1'b0;
         end
         irq_pend_q <= irq_pend_q | {status_set[`DRS_ST_ANALOG_HIGH_VOLTAGE_IRQ], status_set[`DRS_ST_DIGITAL_LOW_VOLTAGE_IRQ],
                                     status_set[`DRS_ST_ANALOG_LOW_VOLTAGE_IRQ]};
         if (wr_stat)
            irq_pend_q <= (irq_pend_q & ~{writedata[`DRS_ST_ANALOG_HIGH_VOLTAGE_IRQ], writedata[`DRS_ST_DIGITAL_LOW_VOLTAGE_IRQ],
                           writedata[`DRS_ST_ANALOG_LOW_VOLTAGE_IRQ]}) | {status_set[`DRS_ST_ANALOG_HIGH_VOLTAGE_IRQ],
                           status_set[`DRS_ST_DIGITAL_LOW_VOLTAGE_IRQ], status_set[`DRS_ST_ANALOG_LOW_VOLTAGE_IRQ]};
      end
   end

   // Monitor enables, registered so the analog side sees clean levels
   wire mon_window = por_done_q & (~in_sleep | buzz_q);
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         initial_power_monitor_mon_en <= 1'b1;
         precise_low_voltage_reset_dig_en <= 1'b0;
         precise_low_voltage_reset_ana_en <= 1'b0;
         analog_reg_en <= 1'b1;
         analog_low_voltage_irq_mon_en <= 1'b0;
         digital_low_voltage_irq_mon_en <= 1'b0;
         analog_high_voltage_irq_mon_en <= 1'b0;
         analog_low_voltage_irq_trip_level <= 4'h0;
         digital_low_voltage_irq_trip_level <= 4'h0;
         monitor_irq <= 1'b0;
         wake_req <= 1'b0;
      end else begin
         initial_power_monitor_mon_en <= ~por_done_q;
         // no software term on digital part
         precise_low_voltage_reset_dig_en <= mon_window;
         precise_low_voltage_reset_ana_en <= mon_window & ctrl_q[`DRS_CTRL_ANA_REG_EN];
         analog_reg_en <= ctrl_q[`DRS_CTRL_ANA_REG_EN];
         analog_low_voltage_irq_mon_en <= mon_window & ctrl_q[`DRS_CTRL_ANALOG_LOW_VOLTAGE_IRQ_EN];
         digital_low_voltage_irq_mon_en <= mon_window & ctrl_q[`DRS_CTRL_DIGITAL_LOW_VOLTAGE_IRQ_EN];
         analog_high_voltage_irq_mon_en <= mon_window & ctrl_q[`DRS_CTRL_ANALOG_HIGH_VOLTAGE_IRQ_EN];
         analog_low_voltage_irq_trip_level <= level_q[3:0];
         digital_low_voltage_irq_trip_level <= level_q[7:4];
         wake_req <= (irq_pend_q != 3'h0) & in_sleep;
         monitor_irq <= (irq_pend_q != 3'h0) & ~in_sleep;
      end
   end

   // handled by raw_rst_n above: pin acts in every mode, trip only while precise_low_voltage_reset_dig_en is high

endmodule

// >>> inc/drs_consts.vh
// Register map, field positions and timing constants of the device reset supervisor
`ifndef DRS_CONSTS_VH
`define DRS_CONSTS_VH

// Register word offsets (byte addresses)
`define DRS_ADDR_W 5
`define DRS_OFS_CTRL 5'h00
`define DRS_OFS_LEVEL 5'h04
`define DRS_OFS_WDT_CTRL 5'h08
`define DRS_OFS_WDT_TIMEOUT 5'h0c
`define DRS_OFS_BUZZ_PERIOD 5'h10
`define DRS_OFS_STATUS 5'h14
`define DRS_OFS_MON_STATE 5'h18

// Control register fields
`define DRS_CTRL_SW_RESET 0
`define DRS_CTRL_SW_BLOCK 1
`define DRS_CTRL_ANA_REG_EN 2
`define DRS_CTRL_ANALOG_LOW_VOLTAGE_IRQ_EN 3
`define DRS_CTRL_DIGITAL_LOW_VOLTAGE_IRQ_EN 4
`define DRS_CTRL_ANALOG_HIGH_VOLTAGE_IRQ_EN 5
`define DRS_CTRL_ANALOG_LOW_VOLTAGE_IRQ_RST 6
`define DRS_CTRL_DIGITAL_LOW_VOLTAGE_IRQ_RST 7
`define DRS_CTRL_RESET 8'h04

// Watchdog control fields
`define DRS_WDT_EN_BIT 0
`define DRS_WDT_KICK_BIT 1
`define DRS_WDT_TIMEOUT_RESET 16'hffff

// Status fields
`define DRS_ST_EXTERNAL_RESET_N 0
`define DRS_ST_PRECISE_LOW_VOLTAGE_RESET 1
`define DRS_ST_SOFTWARE_RESET 2
`define DRS_ST_WATCHDOG_RESET 3
`define DRS_ST_LVI_RST 4
`define DRS_ST_ANALOG_LOW_VOLTAGE_IRQ 5
`define DRS_ST_DIGITAL_LOW_VOLTAGE_IRQ 6
`define DRS_ST_ANALOG_HIGH_VOLTAGE_IRQ 7
`define DRS_ST_IRQ_MASK 8'he0

// Trip levels: code 0 is 1.70 V, each step 250 mV
`define DRS_LEVEL_STEP_MV 250
`define DRS_LEVEL_RESET 8'h00
`define DRS_BUZZ_PERIOD_RESET 16'h0100

// Timing
`define DRS_CLK_PS 8000
`define DRS_INITIAL_POWER_MONITOR_MIN_NS 150
`define DRS_BUZZ_ON_CYC 16
`define DRS_WDT_TICK_CYC 1024

`endif

// >>> tb/drs_rst_sink.sv
// Processor and peripherals as receivers of the device reset
`timescale 1ns/1ps
module drs_rst_sink (
   input wire device_reset_n, // Device reset in
   output logic [7:0] resets_seen // Reset entries
);
   initial resets_seen = 8'h00;
   always @(negedge device_reset_n) resets_seen <= resets_seen + 8'h01;
endmodule

// >>> tb/drs_top_chk.sv
// Concurrent checks on the reset supervisor ports
`timescale 1ns/1ps
module drs_top_chk (
   input wire clk, // Clock
   input wire rst_n, // Power-on reset
   input wire external_reset_n, // Reset pin
   input wire precise_low_voltage_reset_trip, // Precise trip
   input wire sleep_mode, // Sleep
   input wire hibernate_mode, // Hibernate
   input wire read, // Bus read
   input wire write, // Bus write
   input wire waitrequest, // Bus wait
   input wire device_reset_n, // Device reset
   input wire initial_power_monitor_mon_en, // Initial monitor
   input wire precise_low_voltage_reset_dig_en, // Digital precise
   input wire precise_low_voltage_reset_ana_en, // Analog precise
   input wire analog_reg_en, // Regulator
   input wire analog_low_voltage_irq_mon_en, // Analog low
   input wire digital_low_voltage_irq_mon_en, // Digital low
   input wire analog_high_voltage_irq_mon_en, // Analog high
   input wire monitor_irq, // Interrupt
   input wire wake_req // Wake
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   property p_external_reset_n; !external_reset_n |-> !device_reset_n; endproperty
   a_external_reset_n: assert property (p_external_reset_n) else $error("reset pin low, device out of reset");
   property p_precise_low_voltage_reset; precise_low_voltage_reset_trip && precise_low_voltage_reset_dig_en |-> !device_reset_n; endproperty
   a_precise_low_voltage_reset: assert property (p_precise_low_voltage_reset) else $error("precise trip ignored");
   property p_rel; $rose(external_reset_n) && !precise_low_voltage_reset_trip |->
      !device_reset_n [*8] ##[12:14] device_reset_n; endproperty
   a_rel: assert property (p_rel) else $error("device reset release timing off");
   property p_boot; (device_reset_n && !sleep_mode && !hibernate_mode) [*4] |->
      precise_low_voltage_reset_dig_en && !initial_power_monitor_mon_en; endproperty
   a_boot: assert property (p_boot) else $error("supervision not handed over");
   property p_hib; hibernate_mode [*2] |-> !precise_low_voltage_reset_dig_en && !precise_low_voltage_reset_ana_en; endproperty
   a_hib: assert property (p_hib) else $error("precise monitor on in hibernate");
   property p_ana; !analog_reg_en [*2] |-> !precise_low_voltage_reset_ana_en; endproperty
   a_ana: assert property (p_ana) else $error("analog precise on, regulator off");
   property p_mon; !device_reset_n && initial_power_monitor_mon_en |->
      !analog_low_voltage_irq_mon_en && !digital_low_voltage_irq_mon_en && !analog_high_voltage_irq_mon_en; endproperty
   a_mon: assert property (p_mon) else $error("monitor on before power-on done");
   property p_irq; $rose(monitor_irq) |-> !$past(sleep_mode) && !$past(hibernate_mode); endproperty
   a_irq: assert property (p_irq) else $error("interrupt raised while asleep");
   property p_wake; $rose(wake_req) |-> $past(sleep_mode) || $past(hibernate_mode); endproperty
   a_wake: assert property (p_wake) else $error("wake request while awake");
   property p_bus; $rose(read || write) |-> waitrequest ##1 !waitrequest; endproperty
   a_bus: assert property (p_bus) else $error("bus answer not after one wait");
endmodule

// >>> tb/test_drs_top.sv
// Self-checking bench for the device reset supervisor
`timescale 1ns/1ps
module test_drs_top;
   logic clk, rst_n, external_reset_n, precise_low_voltage_reset_trip, analog_low_voltage_irq_cmp, digital_low_voltage_irq_cmp, analog_high_voltage_irq_cmp;
   logic sleep_mode, hibernate_mode, read, write;
   logic [4:0] address;
   logic [7:0] r0;
   logic [31:0] writedata, q, rs;
   wire [31:0] readdata;
   wire waitrequest, device_reset_n, initial_power_monitor_mon_en, precise_low_voltage_reset_dig_en, precise_low_voltage_reset_ana_en, analog_reg_en;
   wire analog_low_voltage_irq_mon_en, digital_low_voltage_irq_mon_en, analog_high_voltage_irq_mon_en, monitor_irq, wake_req;
   wire [3:0] analog_low_voltage_irq_trip_level, digital_low_voltage_irq_trip_level;
   wire [7:0] resets_seen;
   int mismatches, num_checks, n;
   logic [4:0] ra[5] = '{5'h00, 5'h04, 5'h0c, 5'h10, 5'h14};
   logic [31:0] rv[5] = '{32'h4, 32'h0, 32'hffff, 32'h100, 32'h0};
   drs_top #(.WDT_TICK(4)) drs_top_inst (.clk(clk), .rst_n(rst_n),
      .external_reset_n(external_reset_n), .precise_low_voltage_reset_trip(precise_low_voltage_reset_trip), .analog_low_voltage_irq_cmp(analog_low_voltage_irq_cmp),
      .digital_low_voltage_irq_cmp(digital_low_voltage_irq_cmp), .analog_high_voltage_irq_cmp(analog_high_voltage_irq_cmp), .sleep_mode(sleep_mode),
      .hibernate_mode(hibernate_mode), .address(address), .read(read), .write(write),
      .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
      .device_reset_n(device_reset_n), .initial_power_monitor_mon_en(initial_power_monitor_mon_en), .precise_low_voltage_reset_dig_en(precise_low_voltage_reset_dig_en),
      .precise_low_voltage_reset_ana_en(precise_low_voltage_reset_ana_en), .analog_reg_en(analog_reg_en), .analog_low_voltage_irq_mon_en(analog_low_voltage_irq_mon_en),
      .digital_low_voltage_irq_mon_en(digital_low_voltage_irq_mon_en), .analog_high_voltage_irq_mon_en(analog_high_voltage_irq_mon_en), .analog_low_voltage_irq_trip_level(analog_low_voltage_irq_trip_level),
      .digital_low_voltage_irq_trip_level(digital_low_voltage_irq_trip_level), .monitor_irq(monitor_irq), .wake_req(wake_req));
   drs_rst_sink drs_rst_sink_inst (.device_reset_n(device_reset_n), .resets_seen(resets_seen));
   function logic [31:0] rnd();
      rs ^= rs << 13;
      rs ^= rs >> 17;
      rs ^= rs << 5;
      return rs;
   endfunction
   function logic [31:0] st(input int b);
      return 32'h1 << b;
   endfunction
   task stop_test;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch at %0t got %h exp %h", $time, g, e);
      end
   endtask
   task cyc(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   // Held until waitrequest is seen low before the edge
   task bus(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] o);
      int k;
      k = 0;
      @(posedge clk);
      read <= !w;
      write <= w;
      address <= a;
      writedata <= d;
      // Waitrequest and read data taken at the rising edge itself
      do begin
         @(posedge clk);
         k++;
      end while (waitrequest !== 1'b0 && k < 40);
      o = readdata;
      read <= 1'b0;
      write <= 1'b0;
      #1;
      if (k >= 40) chk(k, 0);
   endtask
   task wdr(input logic v, output int k);
      k = 0;
      while (device_reset_n !== v && k < 300) begin
         cyc(1);
         k++;
      end
      chk(device_reset_n, v);
   endtask
   task stat(input int b);
      bus(0, 5'h14, 0, q);
      chk(q & st(b), st(b));
   endtask
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      #200000;
      mismatches++;
      stop_test;
   end
   initial begin
      rs = 32'he7285ec6;
      {rst_n, external_reset_n, precise_low_voltage_reset_trip, analog_low_voltage_irq_cmp, digital_low_voltage_irq_cmp, analog_high_voltage_irq_cmp} = 6'h10;
      {sleep_mode, hibernate_mode, read, write, address, writedata} = 0;
      cyc(10);
      chk(initial_power_monitor_mon_en, 1);
      rst_n <= 1'b1;
      wdr(1, n);
      chk(n >= 18, 1);
      cyc(3);
      chk({precise_low_voltage_reset_dig_en, initial_power_monitor_mon_en, analog_reg_en}, 3'h5);
      for (int i = 0; i < 5; i++) begin
         bus(0, ra[i], 0, q);
         chk(q, rv[i]);
      end
      bus(0, 5'h08, 0, q);
      chk(q[0], 0);
      bus(1, 5'h1c, rnd(), q);
      bus(0, 5'h1c, 0, q);
      chk(q, 0);
      for (int i = 0; i < 5; i++) begin
         r0 = (i == 0) ? 8'hff : rnd();
         bus(1, 5'h04, {24'h0, r0}, q);
         cyc(1);
         chk({digital_low_voltage_irq_trip_level, analog_low_voltage_irq_trip_level}, r0);
      end
      bus(1, 0, 32'h0, q);
      cyc(2);
      chk({analog_reg_en, precise_low_voltage_reset_ana_en, precise_low_voltage_reset_dig_en}, 3'h1);
      bus(1, 0, 32'h3c, q);
      for (int i = 5; i < 8; i++) begin
         {analog_high_voltage_irq_cmp, digital_low_voltage_irq_cmp, analog_low_voltage_irq_cmp} <= 3'h1 << (i - 5);
         cyc(8);
         chk(monitor_irq, 1);
         stat(i);
         {analog_high_voltage_irq_cmp, digital_low_voltage_irq_cmp, analog_low_voltage_irq_cmp} <= 3'h0;
         cyc(6);
         bus(1, 5'h14, st(i), q);
         cyc(1);
         chk(monitor_irq, 0);
      end
      bus(1, 5'h10, 32'h40, q);
      sleep_mode <= 1'b1;
      digital_low_voltage_irq_cmp <= 1'b1;
      n = 0;
      repeat (150) begin
         cyc(1);
         n += precise_low_voltage_reset_dig_en;
      end
      chk(n > 0 && n < 150, 1);
      chk({wake_req, monitor_irq}, 2'h2);
      sleep_mode <= 1'b0;
      cyc(2);
      chk(monitor_irq, 1);
      digital_low_voltage_irq_cmp <= 1'b0;
      hibernate_mode <= 1'b1;
      cyc(4);
      chk(precise_low_voltage_reset_dig_en, 0);
      r0 = resets_seen;
      external_reset_n <= 1'b0;
      #1 chk(device_reset_n, 0);
      cyc(5);
      external_reset_n <= 1'b1;
      hibernate_mode <= 1'b0;
      wdr(1, n);
      chk(n >= 18, 1);
      chk(resets_seen, r0 + 8'h01);
      stat(0);
      bus(1, 0, 32'h6, q);
      bus(1, 0, 32'h7, q);
      cyc(25);
      chk(device_reset_n, 1);
      // Block bit must be cleared before the reset bit is honoured
      bus(1, 0, 32'h4, q);
      bus(1, 0, 32'h5, q);
      cyc(2);
      chk(device_reset_n, 0);
      wdr(1, n);
      stat(2);
      precise_low_voltage_reset_trip <= 1'b1;
      #1 chk(device_reset_n, 0);
      cyc(3);
      precise_low_voltage_reset_trip <= 1'b0;
      wdr(1, n);
      stat(1);
      for (int j = 0; j < 2; j++) begin
         bus(1, 0, 32'h4 | (32'h8 << j) | (32'h40 << j), q);
         cyc(3);
         {digital_low_voltage_irq_cmp, analog_low_voltage_irq_cmp} <= 2'h1 << j;
         cyc(8);
         chk(device_reset_n, 0);
         {digital_low_voltage_irq_cmp, analog_low_voltage_irq_cmp} <= 2'h0;
         wdr(1, n);
         stat(4);
      end
      bus(1, 5'h0c, 32'h10, q);
      bus(1, 5'h08, 32'h1, q);
      bus(1, 5'h08, 32'h0, q);
      bus(0, 5'h08, 0, q);
      chk(q[0], 1);
      repeat (4) begin
         cyc(40);
         bus(1, 5'h08, 32'h3, q);
      end
      chk(device_reset_n, 1);
      wdr(0, n);
      chk(n > 70 && n < 100, 1);
      wdr(1, n);
      stat(3);
      rst_n <= 1'b0;
      cyc(3);
      rst_n <= 1'b1;
      wdr(1, n);
      bus(0, 5'h08, 0, q);
      chk(q[0], 0);
      bus(0, 5'h14, 0, q);
      chk(q, 0);
      stop_test;
   end
endmodule
bind drs_top drs_top_chk drs_top_chk_inst (.clk(clk), .rst_n(rst_n),
   .external_reset_n(external_reset_n), .precise_low_voltage_reset_trip(precise_low_voltage_reset_trip), .sleep_mode(sleep_mode),
   .hibernate_mode(hibernate_mode), .read(read), .write(write), .waitrequest(waitrequest),
   .device_reset_n(device_reset_n), .initial_power_monitor_mon_en(initial_power_monitor_mon_en), .precise_low_voltage_reset_dig_en(precise_low_voltage_reset_dig_en),
   .precise_low_voltage_reset_ana_en(precise_low_voltage_reset_ana_en), .analog_reg_en(analog_reg_en), .analog_low_voltage_irq_mon_en(analog_low_voltage_irq_mon_en),
   .digital_low_voltage_irq_mon_en(digital_low_voltage_irq_mon_en), .analog_high_voltage_irq_mon_en(analog_high_voltage_irq_mon_en), .monitor_irq(monitor_irq),
   .wake_req(wake_req));
